// ---- core/lch_defs.vh ----
// constants for the laser host command handler: register map, characters, reply shapes
// assumes an AXI4-Lite slave with byte addresses and ASCII command characters
`ifndef LCH_DEFS_VH
`define LCH_DEFS_VH
`define LCH_REG_UNIT 6'h00
`define LCH_REG_STATUS 6'h01
`define LCH_REG_TOTAL 6'h02
`define LCH_REG_GOOD 6'h03
`define LCH_UNIT_RST 8'h01
`define LCH_RESP_OKAY 2'h0
`define LCH_RESP_SLVERR 2'h2
`define LCH_CH_ACK 8'h06
`define LCH_CH_NAK 8'h15
`define LCH_CH_ZERO 8'h30
`define LCH_CH_ONE 8'h31
`define LCH_CH_TWO 8'h32
`define LCH_CH_NINE 8'h39
`define LCH_CH_COMMA 8'h2C
`define LCH_CH_SPACE 8'h20
`define LCH_CH_E 8'h45
`define LCH_CH_DOLLAR 8'h24
`define LCH_CH_C 8'h43
`define LCH_CH_R 8'h52
`define LCH_CH_T 8'h54
`define LCH_CH_H 8'h48
`define LCH_CH_V 8'h56
`define LCH_CH_N 8'h4E
`define LCH_LEN_ONE 5'h01
`define LCH_LEN_FAULT 5'h03
`define LCH_LEN_VER 5'h04
`define LCH_LEN_HIST 5'h11
`define LCH_NENT_ONE 4'h1
`define LCH_NENT_VER 4'h3
`define LCH_NENT_HIST 4'hA
`define LCH_SEL_ALL 14'h0063
`define LCH_FRAME_BASE 5'h04
`define LCH_FRAME_HIST 5'h08
`define LCH_FRAME_VER 5'h06
`endif

// ---- core/lch_cmd_handler.v ----
// laser host command handler: parses addressed command frames, acts, and streams replies
// assumes framing and checksum are stripped upstream; rx/tx chars are frame contents only
// Summary of operation
// R01: output-start turns the laser on and answers ACK when ready, else answers NAK only.
// R02: not ready while an alarm is active, pump diode power is off or comm control is off.
// R03: an accepted output-stop ends laser output and answers ACK.
// R04: stop, fault-signal clear and both count clears answer NAK outside comm control mode.
// R05: accepted fault-signal clear drops the fault signal output and answers ACK.
// R06: accepted total-count clear zeroes the total output counter and answers ACK.
// R07: accepted good-count clear zeroes the good output counter and answers ACK.
// R08: every command and reply carries the unit number as two digits, tens first.
// R09: the fault read returns the current fault number as three digits, hundreds first.
// R10: with no fault present the fault read returns 000.
// R11: the history read takes a four-digit index and returns ten entries from there.
// R12: each history entry is twelve date digits, a space, E and three digits, comma separated.
// R13: an empty history slot reads as twelve zeros, a space and E000.
// R14: version selector 00, 01, 02 picks one unit and 99 returns all three.
// R15: the name read returns the configured unit name.
// R16: a frame for another unit number is dropped with no reply.
`timescale 1ns/1ns
`include "lch_defs.vh"
module lch_cmd_handler #(
  parameter HIST_AW = 4,
  parameter NAME_LEN = 8,
  parameter [8*NAME_LEN-1:0] UNIT_NAME = "UNIT0001",
  parameter [15:0] VER_CPU = 16'h0100,
  parameter [15:0] VER_MAIN = 16'h0100,
  parameter [15:0] VER_SUB = 16'h0100
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire rx_end,
  output reg rx_ready,
  output reg tx_valid,
  output reg [7:0] tx_char,
  output reg tx_last,
  input wire tx_ready,
  input wire alarm_active,
  input wire pump_diode_power,
  input wire external_comm_control_mode,
  input wire shot_pulse,
  input wire good_pulse,
  input wire fault_event,
  input wire [11:0] fault_code_digits,
  input wire [47:0] time_digits,
  output reg laser_output,
  output reg fault_signal
);
  localparam S_IDLE = 2'b00;
  localparam S_HDR = 2'b01;
  localparam S_BODY = 2'b10;
  localparam K_ACK = 3'd0;
  localparam K_NAK = 3'd1;
  localparam K_FAULT = 3'd2;
  localparam K_HIST = 3'd3;
  localparam K_VER = 3'd4;
  localparam K_NAME = 3'd5;

  reg [7:0] unit_num;
  reg [31:0] total_output_counter;
  reg [31:0] good_output_counter;
  reg [59:0] hist_mem [0:(1<<HIST_AW)-1];
  reg [HIST_AW-1:0] hist_wp;
  reg [HIST_AW:0] hist_cnt;
  reg [4:0] rx_pos;
  reg [4:0] rx_len;
  reg [7:0] unit_number_digits [0:1];
  reg [7:0] cmd_c1;
  reg [7:0] cmd_c2;
  reg [13:0] arg;
  reg arg_bad;
  reg exec;
  reg [2:0] kind;
  reg [1:0] st;
  reg [3:0] ent;
  reg [3:0] nent;
  reg [4:0] sub;
  reg [4:0] elen;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire unit_ready = !alarm_active && pump_diode_power && external_comm_control_mode; // see R02
  wire rx_take = rx_valid && rx_ready;
  wire is_digit = (rx_char >= `LCH_CH_ZERO) && (rx_char <= `LCH_CH_NINE);
  wire [17:0] arg_mul = {4'h0, arg} * 18'h0000A + {14'h0000, rx_char[3:0]};
  wire [11:0] fault_now = alarm_active ? fault_code_digits : 12'h000; // see R10

  // frame decode, evaluated in the cycle after the last char
  reg d_match;
  reg d_start;
  reg d_stop;
  reg d_clr_fault;
  reg d_clr_total;
  reg d_clr_good;
  reg [2:0] d_kind;
  always @* begin
    d_match = (unit_number_digits[0] == {4'h3, unit_num[7:4]}) &&
              (unit_number_digits[1] == {4'h3, unit_num[3:0]}) &&
              (rx_len >= `LCH_FRAME_BASE); // see R08 see R16
    d_start = 1'b0;
    d_stop = 1'b0;
    d_clr_fault = 1'b0;
    d_clr_total = 1'b0;
    d_clr_good = 1'b0;
    d_kind = K_NAK;
    case ({cmd_c1, cmd_c2})
      {`LCH_CH_DOLLAR, `LCH_CH_ZERO}: begin
        d_start = unit_ready && rx_len == `LCH_FRAME_BASE; // see R01
        d_kind = d_start ? K_ACK : K_NAK;
      end
      {`LCH_CH_DOLLAR, `LCH_CH_NINE}: begin
        d_stop = external_comm_control_mode && rx_len == `LCH_FRAME_BASE; // see R03 see R04
        d_kind = d_stop ? K_ACK : K_NAK;
      end
      {`LCH_CH_C, `LCH_CH_ZERO}: begin
        d_clr_fault = external_comm_control_mode && rx_len == `LCH_FRAME_BASE; // see R04 see R05
        d_kind = d_clr_fault ? K_ACK : K_NAK;
      end
      {`LCH_CH_C, `LCH_CH_ONE}: begin
        d_clr_total = external_comm_control_mode && rx_len == `LCH_FRAME_BASE; // see R04 see R06
        d_kind = d_clr_total ? K_ACK : K_NAK;
      end
      {`LCH_CH_C, `LCH_CH_TWO}: begin
        d_clr_good = external_comm_control_mode && rx_len == `LCH_FRAME_BASE; // see R04 see R07
        d_kind = d_clr_good ? K_ACK : K_NAK;
      end
      {`LCH_CH_R, `LCH_CH_T}: begin
        d_kind = (rx_len == `LCH_FRAME_BASE) ? K_FAULT : K_NAK; // see R09
      end
      {`LCH_CH_R, `LCH_CH_H}: begin
        d_kind = (rx_len == `LCH_FRAME_HIST && !arg_bad) ? K_HIST : K_NAK; // see R11
      end
      {`LCH_CH_R, `LCH_CH_V}: begin
        d_kind = (rx_len == `LCH_FRAME_VER && !arg_bad &&
                  (arg <= 14'h0002 || arg == `LCH_SEL_ALL)) ? K_VER : K_NAK; // see R14
      end
      {`LCH_CH_R, `LCH_CH_N}: begin
        d_kind = (rx_len == `LCH_FRAME_BASE) ? K_NAME : K_NAK; // see R15
      end
      default: begin
        d_kind = K_NAK;
      end
    endcase
  end
  wire act = exec && d_match;

  // reply walker: header digits, then nent entries of elen chars with commas between
  reg [1:0] n_st;
  reg [3:0] n_ent;
  reg [4:0] n_sub;
  always @* begin
    n_st = st;
    n_ent = ent;
    n_sub = sub;
    if (st == S_HDR && sub == 5'h00) begin
      n_sub = 5'h01;
    end else if (st == S_HDR) begin
      n_st = S_BODY;
      n_ent = 4'h0;
      n_sub = 5'h00;
    end else if (sub == elen) begin
      n_ent = ent + 4'h1;
      n_sub = 5'h00;
    end else if (sub < elen - 5'h01) begin
      n_sub = sub + 5'h01;
    end else if (ent < nent - 4'h1) begin
      n_sub = elen;
    end else begin
      n_st = S_IDLE;
    end
  end

  // history slot 0 is the newest record; slots past the record count read as zeros
  wire [14:0] hidx = {1'b0, arg} + {11'h000, n_ent};
  wire hvalid = hidx < {{(14-HIST_AW){1'b0}}, hist_cnt}; // see R13
  wire [HIST_AW-1:0] haddr = hist_wp - {{(HIST_AW-1){1'b0}}, 1'b1} - hidx[HIST_AW-1:0];
  wire [59:0] hrec = hvalid ? hist_mem[haddr] : 60'h000000000000000;
  wire [4:0] hdig = (n_sub < 5'h0C) ? n_sub : n_sub - 5'h02;
  wire [5:0] hbase = 6'h3B - {hdig[3:0], 2'b00};
  wire [1:0] vsel = (arg == `LCH_SEL_ALL) ? n_ent[1:0] : arg[1:0]; // see R14
  wire [47:0] vers = {VER_CPU, VER_MAIN, VER_SUB};
  wire [5:0] vbase = 6'h2F - {vsel, n_sub[1:0], 2'b00};
  wire [3:0] fdig = fault_now[4'hB - {n_sub[1:0], 2'b00} -: 4];
  reg [7:0] nch;
  always @* begin
    nch = `LCH_CH_NAK;
    if (n_st == S_HDR) begin
      nch = {4'h3, unit_num[3:0]}; // see R08
    end else if (n_sub == elen) begin
      nch = `LCH_CH_COMMA; // see R12
    end else begin
      case (kind)
        K_ACK: nch = `LCH_CH_ACK;
        K_NAK: nch = `LCH_CH_NAK;
        K_FAULT: nch = {4'h3, fdig}; // see R09
        K_HIST: begin
          if (n_sub == 5'h0C) begin
            nch = `LCH_CH_SPACE;
          end else if (n_sub == 5'h0D) begin
            nch = `LCH_CH_E;
          end else begin
            nch = {4'h3, hrec[hbase -: 4]}; // see R12
          end
        end
        K_VER: nch = {4'h3, vers[vbase -: 4]};
        K_NAME: nch = UNIT_NAME[8*NAME_LEN-1-8*n_sub -: 8]; // see R15
        default: nch = `LCH_CH_NAK;
      endcase
    end
  end
  wire n_last = (n_st == S_BODY) && (n_ent == nent - 4'h1) && (n_sub == elen - 5'h01);

  // receive side; rx_ready stays low from the last char until the reply is gone
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_pos <= 5'h00;
      rx_len <= 5'h00;
      unit_number_digits[0] <= 8'h00;
      unit_number_digits[1] <= 8'h00;
      cmd_c1 <= 8'h00;
      cmd_c2 <= 8'h00;
      arg <= 14'h0000;
      arg_bad <= 1'b0;
      exec <= 1'b0;
    end else begin
      exec <= 1'b0;
      if (rx_take) begin
        // args kept until the next frame opens: the reply walker still reads them
        if (rx_pos == 5'h00) begin
          arg <= 14'h0000;
          arg_bad <= 1'b0;
        end
        if (rx_pos < 5'h02) begin
          unit_number_digits[rx_pos[0]] <= rx_char; // see R08
        end
        if (rx_pos == 5'h02) begin
          cmd_c1 <= rx_char;
        end
        if (rx_pos == 5'h03) begin
          cmd_c2 <= rx_char;
        end
        if (rx_pos >= `LCH_FRAME_BASE) begin
          arg <= arg_mul[13:0]; // see R11
          arg_bad <= arg_bad || !is_digit;
        end
        if (rx_end) begin
          rx_len <= rx_pos + 5'h01;
          rx_pos <= 5'h00;
          exec <= 1'b1;
        end else if (rx_pos != 5'h1F) begin
          rx_pos <= rx_pos + 5'h01;
        end
      end
    end
  end

  // reply side; a reply only starts after a matching frame, so other units stay silent
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_ready <= 1'b1;
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
      tx_last <= 1'b0;
      st <= S_IDLE;
      ent <= 4'h0;
      sub <= 5'h00;
      nent <= 4'h0;
      elen <= 5'h00;
      kind <= K_NAK;
    end else if (exec) begin
      if (d_match) begin
        kind <= d_kind;
        st <= S_HDR;
        ent <= 4'h0;
        sub <= 5'h00;
        tx_valid <= 1'b1;
        tx_char <= {4'h3, unit_num[7:4]}; // see R08
        tx_last <= 1'b0;
        case (d_kind)
          K_FAULT: begin
            elen <= `LCH_LEN_FAULT;
            nent <= `LCH_NENT_ONE;
          end
          K_HIST: begin
            elen <= `LCH_LEN_HIST;
            nent <= `LCH_NENT_HIST; // see R11
          end
          K_VER: begin
            elen <= `LCH_LEN_VER;
            nent <= (arg == `LCH_SEL_ALL) ? `LCH_NENT_VER : `LCH_NENT_ONE;
          end
          K_NAME: begin
            elen <= NAME_LEN[4:0];
            nent <= `LCH_NENT_ONE;
          end
          default: begin
            elen <= `LCH_LEN_ONE;
            nent <= `LCH_NENT_ONE;
          end
        endcase
      end else begin
        rx_ready <= 1'b1; // see R16
      end
    end else if (tx_valid && tx_ready) begin
      st <= n_st;
      ent <= n_ent;
      sub <= n_sub;
      tx_char <= nch;
      tx_last <= n_last;
      if (n_st == S_IDLE) begin
        tx_valid <= 1'b0;
        rx_ready <= 1'b1;
      end
    end else if (rx_take && rx_end) begin
      rx_ready <= 1'b0;
    end
  end

  // laser output and fault signal; an alarm also ends output as a safety stop
  always @(posedge clk_sys) begin
    if (rst) begin
      laser_output <= 1'b0;
      fault_signal <= 1'b0;
    end else begin
      if (alarm_active || (act && d_stop)) begin
        laser_output <= 1'b0; // see R03
      end else if (act && d_start) begin
        laser_output <= 1'b1; // see R01
      end
      if (fault_event) begin
        fault_signal <= 1'b1;
      end else if (act && d_clr_fault) begin
        fault_signal <= 1'b0; // see R05
      end
    end
  end

  // counters: a shot in the clearing cycle counts as the first after the clear
  always @(posedge clk_sys) begin
    if (rst) begin
      total_output_counter <= 32'h00000000;
      good_output_counter <= 32'h00000000;
      hist_wp <= {HIST_AW{1'b0}};
      hist_cnt <= {(HIST_AW+1){1'b0}};
    end else begin
      if (act && d_clr_total) begin
        total_output_counter <= {31'h00000000, shot_pulse}; // see R06
      end else if (shot_pulse) begin
        total_output_counter <= total_output_counter + 32'h00000001;
      end
      if (act && d_clr_good) begin
        good_output_counter <= {31'h00000000, good_pulse}; // see R07
      end else if (good_pulse) begin
        good_output_counter <= good_output_counter + 32'h00000001;
      end
      if (fault_event) begin
        hist_mem[hist_wp] <= {time_digits, fault_code_digits};
        hist_wp <= hist_wp + {{(HIST_AW-1){1'b0}}, 1'b1};
        if (hist_cnt[HIST_AW] == 1'b0) begin
          hist_cnt <= hist_cnt + {{HIST_AW{1'b0}}, 1'b1};
        end
      end
    end
  end

  // axi4-lite slave; one write and one read in flight, address and data in either order
  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCH_RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      unit_num <= `LCH_UNIT_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr[7:2] == `LCH_REG_UNIT) begin
          s_axi_bresp <= `LCH_RESP_OKAY;
          if (w_strb[0]) begin
            unit_num <= w_data[7:0];
          end
        end else if (aw_addr[7:2] <= `LCH_REG_GOOD) begin
          s_axi_bresp <= `LCH_RESP_OKAY;
        end else begin
          s_axi_bresp <= `LCH_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LCH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `LCH_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `LCH_REG_UNIT: s_axi_rdata <= {24'h000000, unit_num};
        `LCH_REG_STATUS: s_axi_rdata <= {28'h0000000, !rx_ready, unit_ready,
                                         fault_signal, laser_output};
        `LCH_REG_TOTAL: s_axi_rdata <= total_output_counter;
        `LCH_REG_GOOD: s_axi_rdata <= good_output_counter;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `LCH_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // lch_cmd_handler

// ---- verification/lch_cmd_handler_asserts.sv ----
// assertion checker for the laser host command handler, bound to its ports
// assumes the single clock domain and the synchronous active-high reset
`timescale 1ns/1ns
`include "lch_defs.vh"
module lch_cmd_handler_asserts (
  input logic clk_sys,
  input logic rst,
  input logic rx_valid,
  input logic rx_end,
  input logic rx_ready,
  input logic tx_valid,
  input logic [7:0] tx_char,
  input logic tx_last,
  input logic tx_ready,
  input logic alarm_active,
  input logic pump_diode_power,
  input logic external_comm_control_mode,
  input logic fault_event,
  input logic laser_output,
  input logic fault_signal
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence end_taken;
    rx_valid && rx_ready && rx_end;
  endsequence
  sequence answer_due;
    ##2 (tx_valid || rx_ready);
  endsequence
  // a foreign unit number still has to free the link, else the shared bus hangs
  chk_frame_answer: assert property (end_taken |-> answer_due)
    else $error("frame end not followed by reply or release");
  chk_start_ready: assert property ($rose(laser_output) |->
    $past(external_comm_control_mode) && $past(pump_diode_power) && !$past(alarm_active))
    else $error("laser started while not ready");
  chk_alarm_off: assert property (alarm_active |=> !laser_output)
    else $error("laser on during alarm");
  chk_stop_mode: assert property ($fell(laser_output) && !$past(alarm_active) |->
    $past(external_comm_control_mode))
    else $error("laser stopped outside comm control mode");
  chk_fault_set: assert property (fault_event |=> fault_signal)
    else $error("fault event did not raise fault signal");
  chk_fault_mode: assert property ($fell(fault_signal) |-> $past(external_comm_control_mode))
    else $error("fault signal cleared outside comm control mode");
  chk_unit_first: assert property ($rose(tx_valid) |-> tx_char >= 8'h30 && tx_char <= 8'h39)
    else $error("reply does not open with a unit digit");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_char) && $stable(tx_last))
    else $error("reply char changed before it was taken");
  chk_code_last: assert property (tx_valid && (tx_char == `LCH_CH_ACK ||
    tx_char == `LCH_CH_NAK) |-> tx_last)
    else $error("ack or nak not the final reply char");
endmodule // lch_cmd_handler_asserts
bind lch_cmd_handler lch_cmd_handler_asserts chk_u (.clk_sys, .rst, .rx_valid, .rx_end,
  .rx_ready, .tx_valid, .tx_char, .tx_last, .tx_ready, .alarm_active, .pump_diode_power,
  .external_comm_control_mode, .fault_event, .laser_output, .fault_signal);

// ---- verification/lch_host_model.sv ----
// host-side model: sends command frames over the char link and collects the reply
// assumes send is called right after a rising clock edge
`timescale 1ns/1ns
module lch_host_model (
  input logic clk_sys,
  input logic slow,
  output logic rx_valid,
  output logic [7:0] rx_char,
  output logic rx_end,
  input logic rx_ready,
  input logic tx_valid,
  input logic [7:0] tx_char,
  input logic tx_last,
  output logic tx_ready
);
  logic [1535:0] rep = '0;
  logic done = 1'b0;
  logic stuck = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    rx_end = 1'b0;
    tx_ready = 1'b1;
  end
  // slow mode stalls every other cycle so the handler must hold its reply
  always @(posedge clk_sys) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      rep <= {rep[1527:0], tx_char};
      if (tx_last) begin
        done <= 1'b1;
      end
    end
  end
  task automatic send(string s);
    int n;
    rep = '0;
    done = 1'b0;
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_char <= s[i]; // unit digits tens first, index and selector as given
      rx_end <= (i == s.len() - 1);
      n = 0;
      @(posedge clk_sys);
      while (!rx_ready && n < 100) begin
        @(posedge clk_sys);
        n++;
      end
      if (n == 100) begin
        stuck = 1'b1;
      end
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    // released line shows no stale char
    rx_char <= ~rx_char;
  endtask
endmodule // lch_host_model

// ---- verification/lch_cmd_handler_tb.sv ----
// self-checking bench for the command handler: register reads and host command frames
// assumes the host model drives the char link and collects each reply
`timescale 1ns/1ns
module lch_cmd_handler_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic rx_valid, rx_end, rx_ready, tx_valid, tx_last, tx_ready, laser_output, fault_signal;
  logic [7:0] rx_char, tx_char;
  logic alarm = 1'b0, pump = 1'b1, mode = 1'b0, slow = 1'b0;
  logic shot = 1'b0, good = 1'b0, fault_ev = 1'b0;
  logic [11:0] code = 12'h045;
  logic [47:0] tdig = 48'h202403151230;
  logic [3:0] strb = 4'hF;
  int bad_count = 0;
  int samples_checked = 0;
  string ack = "\006";
  string nak = "\025";
  string zero_ent = "000000000000 E000";
  string sel[5] = '{"00", "01", "02", "99", "05"};
  string ver[5] = '{"0101", "0202", "0303", "0101,0202,0303", "\025"};

  always #5 clk_sys = ~clk_sys;

  lch_cmd_handler #(.VER_CPU(16'h0101), .VER_MAIN(16'h0202), .VER_SUB(16'h0303)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_end(rx_end), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready),
    .alarm_active(alarm), .pump_diode_power(pump), .external_comm_control_mode(mode),
    .shot_pulse(shot), .good_pulse(good), .fault_event(fault_ev),
    .fault_code_digits(code), .time_digits(tdig),
    .laser_output(laser_output), .fault_signal(fault_signal));

  lch_host_model host_u (.clk_sys(clk_sys), .slow(slow), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_end(rx_end), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(string what, logic [1535:0] seen, logic [1535:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic timeout(string what);
    bad_count++;
    $display("unexpected %s expected answer seen timeout", what);
    summarize();
  endtask
  function automatic logic [1535:0] vec(string s);
    logic [1535:0] x;
    x = '0;
    for (int i = 0; i < s.len(); i++) x = {x[1527:0], s[i]};
    return x;
  endfunction
  function automatic string hist(string a, string b);
    string s;
    s = {"01", a, ",", b};
    for (int i = 2; i < 10; i++) s = {s, ",", zero_ent};
    return s;
  endfunction
  // address and data offered together, each dropped once taken
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] resp);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (n == 50) timeout("write");
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp, logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (n == 50) timeout(what);
    check(what, rdata, exp);
    check(what, rresp, er);
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cmd(string f, string e);
    int n;
    int lim;
    lim = (e == "") ? 30 : 900;
    host_u.send(f);
    n = 0;
    while (!host_u.done && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == lim && e != "") timeout(f);
    check(f, host_u.rep, vec(e));
  endtask
  task automatic fault_pulse();
    fault_ev <= 1'b1;
    @(posedge clk_sys);
    fault_ev <= 1'b0;
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk("unit", 8'h00, 32'h01, 2'h0);
    rd_chk("status", 8'h04, 32'h0, 2'h0);
    rd_chk("unmapped", 8'h10, 32'h0, 2'h2);
    axi_wr(8'h10, 32'h0, r);
    check("unmapped write", r, 2'h2);
    cmd("01$0", {"01", nak});
    mode <= 1'b1;
    alarm <= 1'b1;
    cmd("01$0", {"01", nak});
    alarm <= 1'b0;
    pump <= 1'b0;
    cmd("01$0", {"01", nak});
    pump <= 1'b1;
    cmd("01$0", {"01", ack});
    rd_chk("status", 8'h04, 32'h5, 2'h0);
    mode <= 1'b0;
    cmd("01$9", {"01", nak});
    check("laser", laser_output, 1'b1);
    mode <= 1'b1;
    cmd("01$9", {"01", ack});
    check("laser", laser_output, 1'b0);
    fault_pulse();
    mode <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      shot <= 1'b1;
      good <= (i < 2);
      @(posedge clk_sys);
      shot <= 1'b0;
      good <= 1'b0;
      @(posedge clk_sys);
    end
    cmd("01C0", {"01", nak});
    check("fault", fault_signal, 1'b1);
    cmd("01C1", {"01", nak});
    cmd("01C2", {"01", nak});
    rd_chk("total", 8'h08, 32'h3, 2'h0);
    mode <= 1'b1;
    cmd("01C0", {"01", ack});
    check("fault", fault_signal, 1'b0);
    cmd("01C1", {"01", ack});
    rd_chk("total", 8'h08, 32'h0, 2'h0);
    rd_chk("good", 8'h0C, 32'h2, 2'h0);
    cmd("01C2", {"01", ack});
    rd_chk("good", 8'h0C, 32'h0, 2'h0);
    cmd("01RT", "01000");
    alarm <= 1'b1;
    code <= 12'h123;
    tdig <= 48'h202404011745;
    fault_pulse();
    cmd("01RT", "01123");
    alarm <= 1'b0;
    slow <= 1'b1;
    cmd("01RH0000", hist("202404011745 E123", "202403151230 E045"));
    cmd("01RH0001", hist("202403151230 E045", zero_ent));
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) cmd({"01RV", sel[i]}, {"01", ver[i]});
    cmd("01RN", "01UNIT0001");
    cmd("02$0", "");
    strb <= 4'h0;
    axi_wr(8'h00, 32'h05, r);
    check("masked write", r, 2'h0);
    rd_chk("unit", 8'h00, 32'h01, 2'h0);
    strb <= 4'hF;
    axi_wr(8'h00, 32'h02, r);
    check("unit write", r, 2'h0);
    cmd("02RN", "02UNIT0001");
    check("host stall", host_u.stuck, 1'b0);
    summarize();
  end
endmodule // lch_cmd_handler_tb
